//--- core/edmac_ack_out.sv
`timescale 1ns/100ps
`default_nettype none

module edmac_ack_out (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    input  wire edmac_pkg::edmac_ack_cfg_t i_cfg,
    input  wire logic                     i_beat,
    output logic                          o_busy,
    output logic                          o_pin,
    output logic                          o_pin_oe
);
    logic active_r;
    logic active_nxt;
    logic hold_r;
    logic hold_nxt;
    logic tog_r;
    logic tog_nxt;
    logic level;

    ////////////////////////////////////////////////////////////////////////
    // Pulse, stretch and toggle state
    always_comb begin
        hold_nxt   = active_r && i_cfg.negate_wait && !hold_r;
        active_nxt = i_beat || hold_nxt;
        tog_nxt    = tog_r ^ i_beat;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            active_r <= 1'b0;
            hold_r   <= 1'b0;
            tog_r    <= 1'b0;
        end else begin
            active_r <= active_nxt;
            hold_r   <= hold_nxt;
            tog_r    <= tog_nxt;
        end
    end

    assign o_busy   = i_cfg.negate_wait && active_r;
    assign level    = i_cfg.toggle_sel ? tog_r : active_r;
    assign o_pin    = i_cfg.polarity ? (i_cfg.out_enable && level)
                                     : !(i_cfg.out_enable && level);
    assign o_pin_oe = i_cfg.out_enable;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_toggle_flip: assert property (
        i_beat && i_cfg.toggle_sel && i_cfg.out_enable ##1 $stable(i_cfg)
        |-> o_pin != $past(o_pin))
        else $error("Ack pin did not toggle on a beat");

    a_negate_wait: assert property (
        i_beat && i_cfg.negate_wait && !i_cfg.toggle_sel
        |=> active_r ##1 active_r)
        else $error("Ack assertion not stretched by negate wait");

    a_out_drive: assert property (
        i_beat && i_cfg.out_enable && !i_cfg.toggle_sel ##1 $stable(i_cfg)
        |-> o_pin_oe && (o_pin == i_cfg.polarity))
        else $error("Enabled ack pin not driven active after a beat");

    a_idle_level: assert property (
        !active_r && !i_cfg.toggle_sel |-> o_pin == !i_cfg.polarity)
        else $error("Idle ack pin not at inactive polarity level");

    a_disabled_hold: assert property (
        !i_cfg.out_enable && $past(i_beat) |-> !o_pin_oe && (o_pin == !i_cfg.polarity))
        else $error("Disabled ack pin left its inactive level");

endmodule
`default_nettype wire

//--- core/edmac_channel.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "edmac_consts.svh"

module edmac_channel #(
    parameter int DATA_W     = 32,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic              i_ext_req,
    input  wire logic              i_periph_req,
    input  wire logic              i_cmp_match,
    input  wire logic [DATA_W-1:0] i_src_data,
    input  wire logic              i_src_valid,
    output logic                   o_src_ready,
    output logic      [DATA_W-1:0] o_ext_data,
    output logic                   o_ext_we,
    output logic                   o_ext_transfer_ack_pin,
    output logic                   o_ext_transfer_ack_pin_oe
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    edmac_pkg::edmac_state_t   state_r;
    edmac_pkg::edmac_state_t   state_nxt;
    edmac_pkg::edmac_ack_cfg_t ack_cfg_r;
    edmac_pkg::edmac_ack_cfg_t ack_cfg_nxt;
    logic [9:0]        xfer_count_r;
    logic [9:0]        xfer_count_nxt;
    logic [9:0]        block_count_r;
    logic [9:0]        block_count_nxt;
    logic [1:0]        mode_r;
    logic [1:0]        mode_nxt;
    logic [1:0]        src_r;
    logic [1:0]        src_nxt;
    logic              enable_r;
    logic              enable_nxt;
    logic              pending_r;
    logic              pending_nxt;
    logic [10:0]       xfer_left_r;
    logic [10:0]       xfer_left_nxt;
    logic [10:0]       blocks_left_r;
    logic [10:0]       blocks_left_nxt;
    logic [10:0]       burst_left_r;
    logic [10:0]       burst_left_nxt;
    logic [DATA_W-1:0] ext_data_r;
    logic [DATA_W-1:0] ext_data_nxt;
    logic              ext_we_r;
    logic              ext_we_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              req_meta_r;
    logic              req_sync_r;
    logic              req_prev_r;
    logic              wr_en;
    logic              rd_setup;
    logic              addr_ok;
    logic              start;
    logic              sw_req;
    logic              req_evt;
    logic              beat;
    logic              burst_end;
    logic              ack_busy;
    logic              fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic [LW-1:0]     fifo_level;
    logic [10:0]       count_units;
    logic [10:0]       block_units;
    logic [10:0]       cluster_units;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign o_pready  = 1'b1;
    assign wr_en     = i_psel && i_penable && i_pwrite && addr_ok;
    assign rd_setup  = i_psel && !i_penable && !i_pwrite;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign o_prdata  = prdata_r;

    assign addr_ok = (i_paddr == `EDMAC_OFF_XFER_COUNT) || (i_paddr == `EDMAC_OFF_BLOCK_COUNT)
                     || (i_paddr == `EDMAC_OFF_XFER_MODE) || (i_paddr == `EDMAC_OFF_ACK_OUTPUT)
                     || (i_paddr == `EDMAC_OFF_SW_REQUEST) || (i_paddr == `EDMAC_OFF_STATUS);

    // Read data captured in the setup phase
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_setup) begin
            if (i_paddr == `EDMAC_OFF_XFER_COUNT) begin
                prdata_nxt = {22'h00_0000, xfer_count_r};
            end else if (i_paddr == `EDMAC_OFF_BLOCK_COUNT) begin
                prdata_nxt = {22'h00_0000, block_count_r};
            end else if (i_paddr == `EDMAC_OFF_XFER_MODE) begin
                prdata_nxt = {27'h000_0000, enable_r, src_r, mode_r};
            end else if (i_paddr == `EDMAC_OFF_ACK_OUTPUT) begin
                prdata_nxt = {28'h000_0000, ack_cfg_r};
            end else if (i_paddr == `EDMAC_OFF_STATUS) begin
                prdata_nxt = {5'h00, xfer_left_r, {(8 - LW){1'b0}}, fifo_level,
                              5'h00, pending_r, (state_r == edmac_pkg::EDMAC_ST_RUN),
                              enable_r};
            end else begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request sources
    assign sw_req  = wr_en && (i_paddr == `EDMAC_OFF_SW_REQUEST) && i_pwdata[0];
    assign start   = wr_en && (i_paddr == `EDMAC_OFF_XFER_MODE)
                     && i_pwdata[`EDMAC_ENABLE_BIT] && !enable_r;

    always_comb begin
        case (src_r)
            `EDMAC_SRC_SOFTWARE: req_evt = sw_req;
            `EDMAC_SRC_EXT_PIN:  req_evt = req_sync_r && !req_prev_r;
            `EDMAC_SRC_PERIPH:   req_evt = i_periph_req;
            default:             req_evt = i_cmp_match;
        endcase
    end

    // Zero field encodes the largest count
    assign count_units   = (xfer_count_r == 10'h000) ? `EDMAC_COUNT_MAX
                                                     : {1'b0, xfer_count_r};
    assign block_units   = (block_count_r == 10'h000) ? `EDMAC_COUNT_MAX
                                                      : {1'b0, block_count_r};
    assign cluster_units = (xfer_count_r[2:0] == 3'h0) ? `EDMAC_CLUSTER_MAX
                                                       : {8'h00, xfer_count_r[2:0]};

    assign beat      = (state_r == edmac_pkg::EDMAC_ST_RUN) && fifo_valid && !ack_busy;
    assign burst_end = beat && (burst_left_r == 11'h001);

    ////////////////////////////////////////////////////////////////////////
    // Registers and transfer engine
    always_comb begin
        state_nxt       = state_r;
        ack_cfg_nxt     = ack_cfg_r;
        xfer_count_nxt  = xfer_count_r;
        block_count_nxt = block_count_r;
        mode_nxt        = mode_r;
        src_nxt         = src_r;
        enable_nxt      = enable_r;
        pending_nxt     = pending_r;
        xfer_left_nxt   = xfer_left_r;
        blocks_left_nxt = blocks_left_r;
        burst_left_nxt  = burst_left_r;
        ext_data_nxt    = ext_data_r;
        ext_we_nxt      = beat;
        if (beat) begin
            ext_data_nxt   = fifo_data;
            burst_left_nxt = burst_left_r - 11'h001;
        end
        case (state_r)
            edmac_pkg::EDMAC_ST_IDLE: begin
                if (enable_r && pending_r) begin
                    pending_nxt = 1'b0;
                    state_nxt   = edmac_pkg::EDMAC_ST_RUN;
                    if (mode_r == `EDMAC_MODE_BLOCK) begin
                        burst_left_nxt = count_units;
                    end else if (mode_r == `EDMAC_MODE_CLUSTER) begin
                        burst_left_nxt = cluster_units;
                    end else begin
                        burst_left_nxt = 11'h001;
                    end
                end
            end
            edmac_pkg::EDMAC_ST_RUN: begin
                if (burst_end) begin
                    state_nxt = edmac_pkg::EDMAC_ST_IDLE;
                    if (mode_r == `EDMAC_MODE_NORMAL) begin
                        xfer_left_nxt = xfer_left_r - 11'h001;
                        if (xfer_left_r == 11'h001) begin
                            enable_nxt = 1'b0;
                        end
                    end else if (mode_r == `EDMAC_MODE_REPEAT) begin
                        xfer_left_nxt = xfer_left_r - 11'h001;
                        if (xfer_left_r == 11'h001) begin
                            xfer_left_nxt = count_units;
                        end
                    end else if (mode_r == `EDMAC_MODE_BLOCK) begin
                        blocks_left_nxt = blocks_left_r - 11'h001;
                        if (blocks_left_r == 11'h001) begin
                            enable_nxt = 1'b0;
                        end
                    end
                end
            end
            default: state_nxt = edmac_pkg::EDMAC_ST_IDLE;
        endcase
        if (wr_en) begin
            if (i_paddr == `EDMAC_OFF_XFER_COUNT) begin
                xfer_count_nxt = i_pwdata[9:0];
            end else if (i_paddr == `EDMAC_OFF_BLOCK_COUNT) begin
                block_count_nxt = i_pwdata[9:0];
            end else if (i_paddr == `EDMAC_OFF_XFER_MODE) begin
                mode_nxt   = i_pwdata[`EDMAC_MODE_LSB +: 2];
                src_nxt    = i_pwdata[`EDMAC_SRC_LSB +: 2];
                enable_nxt = i_pwdata[`EDMAC_ENABLE_BIT];
                if (!i_pwdata[`EDMAC_ENABLE_BIT]) begin
                    state_nxt   = edmac_pkg::EDMAC_ST_IDLE;
                    pending_nxt = 1'b0;
                end
            end else if (i_paddr == `EDMAC_OFF_ACK_OUTPUT) begin
                ack_cfg_nxt = i_pwdata[3:0];
            end
        end
        if (start) begin
            xfer_left_nxt   = count_units;
            blocks_left_nxt = block_units;
            pending_nxt     = 1'b0;
            state_nxt       = edmac_pkg::EDMAC_ST_IDLE;
        end
        if (req_evt) begin
            pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r       <= edmac_pkg::EDMAC_ST_IDLE;
            ack_cfg_r     <= `EDMAC_RST_ACK;
            xfer_count_r  <= `EDMAC_RST_COUNT;
            block_count_r <= `EDMAC_RST_COUNT;
            mode_r        <= `EDMAC_RST_MODE;
            src_r         <= `EDMAC_RST_SRC;
            enable_r      <= 1'b0;
            pending_r     <= 1'b0;
            xfer_left_r   <= `EDMAC_COUNT_MAX;
            blocks_left_r <= `EDMAC_COUNT_MAX;
            burst_left_r  <= 11'h001;
            ext_data_r    <= '0;
            ext_we_r      <= 1'b0;
            prdata_r      <= 32'h0000_0000;
            req_meta_r    <= 1'b0;
            req_sync_r    <= 1'b0;
            req_prev_r    <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            ack_cfg_r     <= ack_cfg_nxt;
            xfer_count_r  <= xfer_count_nxt;
            block_count_r <= block_count_nxt;
            mode_r        <= mode_nxt;
            src_r         <= src_nxt;
            enable_r      <= enable_nxt;
            pending_r     <= pending_nxt;
            xfer_left_r   <= xfer_left_nxt;
            blocks_left_r <= blocks_left_nxt;
            burst_left_r  <= burst_left_nxt;
            ext_data_r    <= ext_data_nxt;
            ext_we_r      <= ext_we_nxt;
            prdata_r      <= prdata_nxt;
            req_meta_r    <= i_ext_req;
            req_sync_r    <= req_meta_r;
            req_prev_r    <= req_sync_r;
        end
    end

    assign o_ext_data = ext_data_r;
    assign o_ext_we   = ext_we_r;

    ////////////////////////////////////////////////////////////////////////
    // Data buffer and acknowledge pin
    edmac_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_wr_data  (i_src_data),
        .i_wr_valid (i_src_valid),
        .o_wr_ready (o_src_ready),
        .o_rd_data  (fifo_data),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (beat),
        .o_level    (fifo_level)
    );

    edmac_ack_out u_ack (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_cfg     (ack_cfg_r),
        .i_beat    (beat),
        .o_busy    (ack_busy),
        .o_pin     (o_ext_transfer_ack_pin),
        .o_pin_oe  (o_ext_transfer_ack_pin_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_zero_count_max: assert property (
        start && (xfer_count_r == 10'h000)
        |=> xfer_left_r == 11'h400)
        else $error("Zero transfer count not loaded as 1024");
    a_cluster_size: assert property (
        (state_r == edmac_pkg::EDMAC_ST_IDLE) && enable_r && pending_r && !wr_en
        && (mode_r == `EDMAC_MODE_CLUSTER) && (xfer_count_r[2:0] == 3'h0)
        |=> (burst_left_r == 11'h008) && (state_r == edmac_pkg::EDMAC_ST_RUN))
        else $error("Zero cluster size not taken as 8");
    a_normal_end: assert property (
        burst_end && (mode_r == `EDMAC_MODE_NORMAL) && (xfer_left_r == 11'h001)
        && !wr_en |=> !enable_r ##1 !o_ext_we || !beat)
        else $error("Normal mode did not end on its transfer count");
    a_normal_no_block: assert property (
        (mode_r == `EDMAC_MODE_NORMAL) && !start |=> $stable(blocks_left_r))
        else $error("Block count used in normal mode");
    a_cmp_request: assert property (
        enable_r && (src_r == `EDMAC_SRC_CMP_MATCH) && i_cmp_match && !wr_en
        && (state_r == edmac_pkg::EDMAC_ST_IDLE) && !pending_r
        |=> pending_r ##1 (state_r == edmac_pkg::EDMAC_ST_RUN))
        else $error("Compare match did not start a transfer");
    c_block_done: cover property (
        burst_end && (mode_r == `EDMAC_MODE_BLOCK) && (blocks_left_r == 11'h001));
    c_repeat_reload: cover property (
        burst_end && (mode_r == `EDMAC_MODE_REPEAT) && (xfer_left_r == 11'h001));
    c_cluster_run: cover property (
        beat && (mode_r == `EDMAC_MODE_CLUSTER) ##1 beat);
    c_fifo_full: cover property (!o_src_ready && i_src_valid);

endmodule
`default_nettype wire

//--- core/edmac_consts.svh
`ifndef EDMAC_CONSTS_SVH
`define EDMAC_CONSTS_SVH

// Register byte offsets
`define EDMAC_OFF_XFER_COUNT  8'h00
`define EDMAC_OFF_BLOCK_COUNT 8'h04
`define EDMAC_OFF_XFER_MODE   8'h08
`define EDMAC_OFF_ACK_OUTPUT  8'h0C
`define EDMAC_OFF_SW_REQUEST  8'h10
`define EDMAC_OFF_STATUS      8'h14

// Field positions of the mode register
`define EDMAC_MODE_LSB        0
`define EDMAC_SRC_LSB         2
`define EDMAC_ENABLE_BIT      4

// Transfer modes
`define EDMAC_MODE_NORMAL     2'b00
`define EDMAC_MODE_REPEAT     2'b01
`define EDMAC_MODE_BLOCK      2'b10
`define EDMAC_MODE_CLUSTER    2'b11

// Request sources
`define EDMAC_SRC_SOFTWARE    2'b00
`define EDMAC_SRC_EXT_PIN     2'b01
`define EDMAC_SRC_PERIPH      2'b10
`define EDMAC_SRC_CMP_MATCH   2'b11

// Count encodings: a zero field means the largest value
`define EDMAC_COUNT_MAX       11'h400
`define EDMAC_CLUSTER_MAX     11'h008

// Reset values
`define EDMAC_RST_COUNT       10'h000
`define EDMAC_RST_MODE        2'b00
`define EDMAC_RST_SRC         2'b00
`define EDMAC_RST_ACK         4'h0

`endif

//--- core/edmac_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module edmac_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    output logic      [WIDTH-1:0] o_rd_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic      [AW:0]      o_level
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      level_r;
    logic [AW:0]      level_nxt;
    logic             push;
    logic             pop;

    assign o_wr_ready = (level_r != DEPTH[AW:0]);
    assign o_rd_valid = (level_r != '0);
    assign o_rd_data  = mem_r[rd_ptr_r];
    assign o_level    = level_r;
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = i_rd_ready && o_rd_valid;

    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
        level_nxt  = level_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            level_r  <= level_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_wr_data;
        end
    end

endmodule
`default_nettype wire

//--- core/edmac_pkg.sv
package edmac_pkg;

    // Acknowledge output settings, bit 3 down to bit 0
    typedef struct packed {
        logic polarity;
        logic out_enable;
        logic negate_wait;
        logic toggle_sel;
    } edmac_ack_cfg_t;

    typedef enum logic [0:0] {
        EDMAC_ST_IDLE,
        EDMAC_ST_RUN
    } edmac_state_t;

endpackage

//--- dv/edmac_channel_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "edmac_consts.svh"

module edmac_channel_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, src_data = 32'h0000_0000, ext_data;
    logic pready, pslverr, slv, periph = 1'b0, cmp = 1'b0, src_valid = 1'b0, src_ready;
    logic we, pin, oe, act_hi = 1'b0;
    int   err_total = 0, tests_run = 0, words, act, flips, k;
    logic [31:0] last;

    edmac_channel dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ext_req(1'b0), .i_periph_req(periph),
        .i_cmp_match(cmp), .i_src_data(src_data), .i_src_valid(src_valid),
        .o_src_ready(src_ready), .o_ext_data(ext_data), .o_ext_we(we),
        .o_ext_transfer_ack_pin(pin), .o_ext_transfer_ack_pin_oe(oe));
    edmac_ext_sink sink (.i_ref_clk(clk), .i_rst(rst), .i_we(we), .i_data(ext_data),
        .i_pin(pin), .i_pin_oe(oe), .i_active_high(act_hi), .o_words(words),
        .o_last(last), .o_act(act), .o_flips(flips));

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reset_dut();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin chk(0, 1); summarize(); end
        @(posedge clk);
    endtask

    task automatic fill(input int n);
        k = 0;
        src_valid <= 1'b1; src_data <= 32'h0000_A000;
        for (int c = 0; c < 40 && k < n; c++) begin
            @(posedge clk);
            if (src_ready === 1'b1) begin k++; src_data <= 32'h0000_A000 + k; end
        end
        src_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse(input logic use_cmp);
        if (use_cmp) cmp <= 1'b1;
        else periph <= 1'b1;
        @(posedge clk);
        cmp <= 1'b0;
        periph <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    task automatic wait_words(input int n);
        for (int c = 0; c < 300 && words < n; c++) @(posedge clk);
        if (words < n) begin chk(words, n); summarize(); end
        repeat (20) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs();
        reset_dut();
        chk(pin, 1'b1);
        chk(oe, 1'b0);
        apb(1'b0, `EDMAC_OFF_ACK_OUTPUT, 0); chk(rd, 32'h0000_0000);
        apb(1'b1, `EDMAC_OFF_ACK_OUTPUT, 32'h0000_00FF);
        apb(1'b0, `EDMAC_OFF_ACK_OUTPUT, 0); chk(rd, 32'h0000_000F);
        chk(oe, 1'b1);
        apb(1'b0, 8'h20, 0); chk({rd[30:0], slv}, 32'h0000_0001);
    endtask

    task automatic s_normal();
        reset_dut();
        apb(1'b1, `EDMAC_OFF_BLOCK_COUNT, 32'h0000_0005);
        apb(1'b1, `EDMAC_OFF_XFER_COUNT, 32'h0000_0002);
        fill(4);
        apb(1'b1, `EDMAC_OFF_XFER_MODE, 32'h0000_001C);
        pulse(1'b0);
        chk(words, 0);
        pulse(1'b1); pulse(1'b1);
        wait_words(2);
        pulse(1'b1);
        chk(words, 2);
        chk(last, 32'h0000_A001);
        chk(flips, 0);
        apb(1'b0, `EDMAC_OFF_STATUS, 0); chk(rd[0], 1'b0);
    endtask

    task automatic s_cluster();
        reset_dut();
        act_hi <= 1'b1;
        apb(1'b1, `EDMAC_OFF_ACK_OUTPUT, 32'h0000_000C);
        apb(1'b1, `EDMAC_OFF_XFER_COUNT, 32'h0000_0000);
        fill(17);
        chk(k, 16);
        chk(src_ready, 1'b0);
        apb(1'b1, `EDMAC_OFF_XFER_MODE, 32'h0000_001F);
        pulse(1'b1); wait_words(8);
        chk(words, 8);
        chk(act, 8);
        pulse(1'b1); wait_words(16);
        chk(last, 32'h0000_A00F);
        chk(src_ready, 1'b1);
    endtask

    task automatic s_ack(input logic [31:0] cfg, input int exp_act, input int exp_flips);
        reset_dut();
        act_hi <= cfg[3];
        apb(1'b1, `EDMAC_OFF_ACK_OUTPUT, cfg);
        apb(1'b1, `EDMAC_OFF_XFER_COUNT, 32'h0000_0003);
        fill(3);
        apb(1'b1, `EDMAC_OFF_XFER_MODE, 32'h0000_001C);
        pulse(1'b1); pulse(1'b1); pulse(1'b1);
        wait_words(3);
        if (exp_act >= 0) chk(act, exp_act);
        if (exp_flips >= 0) chk(flips, exp_flips);
    endtask

    task automatic s_block();
        reset_dut();
        apb(1'b1, `EDMAC_OFF_XFER_COUNT, 32'h0000_0003);
        apb(1'b1, `EDMAC_OFF_BLOCK_COUNT, 32'h0000_0002);
        fill(7);
        apb(1'b1, `EDMAC_OFF_XFER_MODE, 32'h0000_001E);
        pulse(1'b1);
        chk(words, 3);
        pulse(1'b1); pulse(1'b1);
        chk(words, 6);
        chk(last, 32'h0000_A005);
    endtask

    task automatic s_repeat();
        reset_dut();
        apb(1'b1, `EDMAC_OFF_XFER_COUNT, 32'h0000_0002);
        fill(3);
        apb(1'b1, `EDMAC_OFF_XFER_MODE, 32'h0000_0011);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `EDMAC_OFF_SW_REQUEST, 32'h0000_0001);
            repeat (8) @(posedge clk);
        end
        chk(words, 3);
        apb(1'b0, `EDMAC_OFF_STATUS, 0); chk(rd[0], 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        s_regs();
        s_normal();
        s_cluster();
        s_ack(32'h0000_000E, 6, -1);
        s_ack(32'h0000_0005, -1, 3);
        s_block();
        s_repeat();
        summarize();
    end
endmodule
`default_nettype wire

//--- dv/edmac_ext_sink.sv
`timescale 1ns/100ps
`default_nettype none

module edmac_ext_sink (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_we,
    input  wire logic [31:0] i_data,
    input  wire logic        i_pin,
    input  wire logic        i_pin_oe,
    input  wire logic        i_active_high,
    output int               o_words,
    output logic [31:0]      o_last,
    output int               o_act,
    output int               o_flips
);
    logic prev_pin;
    // Pulled-up wire when the pin is not driven
    wire  line = i_pin_oe ? i_pin : 1'b1;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_words  <= 0;
            o_act    <= 0;
            o_flips  <= 0;
            o_last   <= 32'h0000_0000;
            prev_pin <= i_pin;
        end else begin
            prev_pin <= i_pin;
            if (i_we === 1'b1) begin
                o_words <= o_words + 1;
                o_last  <= i_data;
            end
            if (i_pin_oe === 1'b1 && line === i_active_high) o_act <= o_act + 1;
            if (i_pin !== prev_pin) o_flips <= o_flips + 1;
        end
    end
endmodule
`default_nettype wire
